// [verilog/mcrtc_map.svh]
/*
 * Register offset, field positions, reset value and timing counts of the
 * main clock controller with time base.
 * Assumes inclusion by bare name from design files.
 */
`ifndef MCRTC_MAP_SVH
`define MCRTC_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define MCRTC_CSR_ADDR      12'h000
`define MCRTC_CSR_RESET     8'h00

// ****************************************
// Field positions
// ****************************************
`define MCRTC_BIT_CLKOUT    7
`define MCRTC_BIT_CP_HI     6
`define MCRTC_BIT_CP_LO     5
`define MCRTC_BIT_SMS       4
`define MCRTC_BIT_TB_HI     3
`define MCRTC_BIT_TB_LO     2
`define MCRTC_BIT_OIE       1
`define MCRTC_BIT_OIF       0

// ****************************************
// Time-base period lengths in master clock cycles
// ****************************************
`define MCRTC_TB_LEN0       16000
`define MCRTC_TB_LEN1       32000
`define MCRTC_TB_LEN2       80000
`define MCRTC_TB_LEN3       200000

`endif

// [verilog/mcrtc_pkg.sv]
/*
 * Types of the main clock controller with time base.
 * Assumes nothing of its surroundings.
 */
package mcrtc_pkg;

    // ****************************************
    // Power mode of the device
    // ****************************************
    typedef enum logic [1:0] {
        MCRTC_RUN,
        MCRTC_WAIT,
        MCRTC_ACTIVE_HALT,
        MCRTC_HALT
    } mcrtc_mode_type;

endpackage

// [verilog/mcrtc_top.sv]
/*
 * Main clock controller with periodic time base: slow-mode CPU clock divider,
 * programmable time-base counter with overflow flag, clock output on a pin,
 * and the power-mode tracking that gates them. One APB register.
 * Assumes the CPU reports halt/wait instructions and wake events as one-cycle
 * pulses on pclk, and that the master clock equals pclk.
 */
`timescale 1ns/1ns
`include "mcrtc_map.svh"

// Behaviour
// - Slow select 0 gives CPU clock equal master clock; 1 gives divided clock.
// - Prescaler bits 6:5 divide master clock by 2, 4, 8 or 16.
// - Time-base code sets period 16000, 32000, 80000 or 200000 cycles.
// - New time-base code is applied only when the running period completes.
// - Each period sets overflow flag; request needs enable set and CPU mask clear.
// - Clock-output bit 7 drives the master clock at half rate onto the pin, else pin is GPIO.
// - Clock output is inactive in Active-halt even when the bit is set.
// - In Wait the block runs normally and the time-base interrupt wakes it.
// - In Active-halt the counter runs, registers hold, interrupt wakes device.
// - In Halt counter and registers freeze until a halt-capable wake.
// - Time-base interrupt cannot wake from Halt, only from Wait and Active-halt.
// - Halt instruction with overflow enable set enters Active-halt instead of Halt.
// - Reset clears every bit of the control/status register.
// - After reset the device runs in normal mode from the master clock.
// - In slow mode CPU and peripherals both use the divided clock.
// - Wait entered during slow mode keeps the divided clock (slow-wait).

module mcrtc_top #(
    parameter int unsigned TB_LEN0 = `MCRTC_TB_LEN0,
    parameter int unsigned TB_LEN1 = `MCRTC_TB_LEN1,
    parameter int unsigned TB_LEN2 = `MCRTC_TB_LEN2,
    parameter int unsigned TB_LEN3 = `MCRTC_TB_LEN3
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_irq_masked,
    input  wire logic        halt_instr,
    input  wire logic        wait_instr,
    input  wire logic        ext_wake,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             clock_output_pin_o,
    output logic             clock_output_pin_oe,
    output logic             tb_irq,
    output logic             cpu_stopped,
    output logic             osc_running
);

    // ****************************************
    // Register state
    // ****************************************
    logic                        clock_output_enable_r;
    logic [1:0]                  slow_clock_prescaler_r;
    logic                        slow_mode_select_r;
    logic [1:0]                  time_base_select_r;
    logic                        overflow_irq_enable_r;
    logic                        overflow_flag_r;
    logic [1:0]                  tb_active_r;
    logic [17:0]                 tb_count_r;
    logic [3:0]                  div_count_r;
    logic                        pin_toggle_r;
    mcrtc_pkg::mcrtc_mode_type   mode_r;

    logic       access;
    logic       wr_en;
    logic       rd_en;
    logic       addr_hit;
    logic       regs_frozen;
    logic       tb_running;
    logic       tb_wrap;
    logic [7:0] csr_value;
    logic [3:0] div_mask;

    function automatic logic [17:0] tb_len(input logic [1:0] code);
        case (code)
            2'h0:    tb_len = 18'(TB_LEN0);
            2'h1:    tb_len = 18'(TB_LEN1);
            2'h2:    tb_len = 18'(TB_LEN2);
            default: tb_len = 18'(TB_LEN3);
        endcase
    endfunction

    assign access      = psel && penable;
    assign addr_hit    = (paddr == `MCRTC_CSR_ADDR);
    assign wr_en       = access && pwrite && addr_hit && pstrb[0];
    assign rd_en       = access && !pwrite && addr_hit;
    assign regs_frozen = (mode_r == mcrtc_pkg::MCRTC_ACTIVE_HALT) || (mode_r == mcrtc_pkg::MCRTC_HALT);
    assign tb_running  = (mode_r != mcrtc_pkg::MCRTC_HALT);
    assign tb_wrap     = tb_running && (tb_count_r == tb_len(tb_active_r) - 18'h00001);
    assign csr_value   = {clock_output_enable_r, slow_clock_prescaler_r, slow_mode_select_r,
                          time_base_select_r, overflow_irq_enable_r, overflow_flag_r};
    assign div_mask    = 4'((5'h02 << slow_clock_prescaler_r) - 5'h01);

    // ****************************************
    // APB slave: zero wait states, error on unmapped address
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr != `MCRTC_CSR_ADDR);
            if (psel && !penable && !pwrite && (paddr == `MCRTC_CSR_ADDR)) begin
                prdata <= {24'h000000, csr_value};
            end else if (psel && !penable) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ****************************************
    // Control fields; writes ignored while the registers are frozen
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_enable_r  <= 1'b0;
            slow_clock_prescaler_r <= 2'h0;
            slow_mode_select_r     <= 1'b0;
            time_base_select_r     <= 2'h0;
            overflow_irq_enable_r  <= 1'b0;
        end else if (wr_en && pready && !regs_frozen) begin
            clock_output_enable_r  <= pwdata[`MCRTC_BIT_CLKOUT];
            slow_clock_prescaler_r <= pwdata[`MCRTC_BIT_CP_HI:`MCRTC_BIT_CP_LO];
            slow_mode_select_r     <= pwdata[`MCRTC_BIT_SMS];
            time_base_select_r     <= pwdata[`MCRTC_BIT_TB_HI:`MCRTC_BIT_TB_LO];
            overflow_irq_enable_r  <= pwdata[`MCRTC_BIT_OIE];
        end
    end

    // ****************************************
    // Overflow flag: a new overflow wins over the read that clears it
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_r <= 1'b0;
        end else if (tb_wrap) begin
            overflow_flag_r <= 1'b1;
        end else if (rd_en && pready) begin
            overflow_flag_r <= 1'b0;
        end
    end

    // ****************************************
    // Time-base counter
    // ****************************************
    // The active code is reloaded only at the wrap so a period never shortens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_count_r  <= 18'h00000;
            tb_active_r <= 2'h0;
        end else if (tb_wrap) begin
            tb_count_r  <= 18'h00000;
            tb_active_r <= time_base_select_r;
        end else if (tb_running) begin
            tb_count_r  <= tb_count_r + 18'h00001;
        end
    end

    // ****************************************
    // Interrupt request
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_irq <= 1'b0;
        end else begin
            tb_irq <= (overflow_flag_r || tb_wrap) && overflow_irq_enable_r && !cpu_irq_masked
                      && !(rd_en && pready && !tb_wrap);
        end
    end

    // ****************************************
    // Power mode tracking
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= mcrtc_pkg::MCRTC_RUN;
        end else begin
            case (mode_r)
                mcrtc_pkg::MCRTC_RUN: begin
                    if (halt_instr) begin
                        mode_r <= overflow_irq_enable_r ? mcrtc_pkg::MCRTC_ACTIVE_HALT
                                                        : mcrtc_pkg::MCRTC_HALT;
                    end else if (wait_instr) begin
                        mode_r <= mcrtc_pkg::MCRTC_WAIT;
                    end
                end
                mcrtc_pkg::MCRTC_WAIT: begin
                    if (ext_wake || (tb_wrap && overflow_irq_enable_r)) begin
                        mode_r <= mcrtc_pkg::MCRTC_RUN;
                    end
                end
                mcrtc_pkg::MCRTC_ACTIVE_HALT: begin
                    if (ext_wake || (tb_wrap && overflow_irq_enable_r)) begin
                        mode_r <= mcrtc_pkg::MCRTC_RUN;
                    end
                end
                mcrtc_pkg::MCRTC_HALT: begin
                    // Only halt-capable wake sources; the time base is stopped anyway
                    if (ext_wake) begin
                        mode_r <= mcrtc_pkg::MCRTC_RUN;
                    end
                end
                default: begin
                    mode_r <= mcrtc_pkg::MCRTC_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Slow-mode clock enables
    // ****************************************
    // Enables rather than a gated clock keep the design on one clock tree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count_r   <= 4'h0;
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
        end else begin
            div_count_r   <= div_count_r + 4'h1;
            if (slow_mode_select_r) begin
                periph_clk_en <= ((div_count_r & div_mask) == div_mask);
            end else begin
                periph_clk_en <= 1'b1;
            end
            cpu_clk_en <= (mode_r == mcrtc_pkg::MCRTC_RUN)
                          && (!slow_mode_select_r || ((div_count_r & div_mask) == div_mask));
        end
    end

    // ****************************************
    // Clock output pin and status
    // ****************************************
    // Pin toggles each cycle: a registered image of the master clock at half rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_toggle_r        <= 1'b0;
            clock_output_pin_o  <= 1'b0;
            clock_output_pin_oe <= 1'b0;
            cpu_stopped         <= 1'b0;
            osc_running         <= 1'b1;
        end else begin
            pin_toggle_r        <= !pin_toggle_r;
            clock_output_pin_oe <= clock_output_enable_r && (mode_r != mcrtc_pkg::MCRTC_ACTIVE_HALT)
                                   && (mode_r != mcrtc_pkg::MCRTC_HALT);
            clock_output_pin_o  <= clock_output_enable_r && pin_toggle_r
                                   && (mode_r == mcrtc_pkg::MCRTC_RUN || mode_r == mcrtc_pkg::MCRTC_WAIT);
            cpu_stopped         <= (mode_r != mcrtc_pkg::MCRTC_RUN);
            osc_running         <= (mode_r != mcrtc_pkg::MCRTC_HALT);
        end
    end

endmodule

// [dv/mcrtc_top_chk.sv]
/* Concurrent checks on the ports of the clock controller with time base.
   Assumes one clock, pclk, and the asynchronous active-low presetn. */
`timescale 1ns/1ns
module mcrtc_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_irq_masked,
    input wire logic        halt_instr,
    input wire logic        ext_wake,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        clock_output_pin_o,
    input wire logic        clock_output_pin_oe,
    input wire logic        tb_irq,
    input wire logic        cpu_stopped,
    input wire logic        osc_running
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****
    // Bus answer and power modes
    // ****
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_halted;
        !osc_running && $past(!osc_running);
    endsequence
    a_apb_answer: assert property (s_setup |=> pready) else $error("no answer to setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_err_decode: assert property (pready |-> pslverr == (paddr != 12'h000)) else $error("bad pslverr");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("prdata high bits");
    a_irq_masked: assert property (cpu_irq_masked |=> !tb_irq) else $error("irq while masked");
    a_halt_enter: assert property (halt_instr && !cpu_stopped |-> ##[1:2] cpu_stopped) else $error("halt ignored");
    a_halt_hold: assert property (!osc_running && !ext_wake && !$past(ext_wake) |=> !osc_running)
        else $error("halt left without wake");
    a_halt_no_out: assert property (s_halted |-> !clock_output_pin_oe) else $error("clock out in halt");
    a_out_toggle: assert property (clock_output_pin_oe && $past(clock_output_pin_oe)
        |-> clock_output_pin_o != $past(clock_output_pin_o)) else $error("clock out stuck");
    a_run_match: assert property (!cpu_stopped && $past(!cpu_stopped) && $past(!cpu_stopped, 2)
        |-> cpu_clk_en == periph_clk_en) else $error("cpu and periph enables differ");
endmodule
bind mcrtc_top mcrtc_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_irq_masked(cpu_irq_masked),
    .halt_instr(halt_instr), .ext_wake(ext_wake), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe), .tb_irq(tb_irq),
    .cpu_stopped(cpu_stopped), .osc_running(osc_running));

// [dv/test_mcrtc_top.sv]
/* Self-checking bench of the clock controller with time base.
   Assumes the time-base lengths shortened to 16, 32, 80 and 200 cycles. */
`timescale 1ns/1ns
module test_mcrtc_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        cpu_irq_masked, halt_instr, wait_instr, ext_wake, cpu_clk_en, periph_clk_en;
    logic        clock_output_pin_o, clock_output_pin_oe, tb_irq, cpu_stopped, osc_running;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic        e;
    int          n_mismatch, check_count, cyc, n, m, t0, t1;
    int          len [4] = '{16, 32, 80, 200};
    mcrtc_top #(.TB_LEN0(16), .TB_LEN1(32), .TB_LEN2(80), .TB_LEN3(200)) i_mcrtc_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_irq_masked(cpu_irq_masked),
        .halt_instr(halt_instr), .wait_instr(wait_instr), .ext_wake(ext_wake), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .clock_output_pin_o(clock_output_pin_o),
        .clock_output_pin_oe(clock_output_pin_oe), .tb_irq(tb_irq), .cpu_stopped(cpu_stopped),
        .osc_running(osc_running));
    // ****
    // Shared tasks
    // ****
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, x, g);
        end
    endtask
    // Entered just after a rising edge; returns one idle edge after the one that sampled pready,
    // so a following call never drives psel twice in one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wait_irq(output int t);
        while (tb_irq !== 1'b0) @(posedge pclk);
        while (tb_irq !== 1'b1) @(posedge pclk);
        t = cyc;
    endtask
    task automatic wait_run(input string s);
        n = 0;
        while (cpu_stopped !== 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(s, 1, n < 300);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        apb(0, 12'h000, 8'h00);
        chk("csr_reset", 32'h00000000, r);
        chk("cpu_en", 1, cpu_clk_en);
        apb(0, 12'h004, 8'h00);
        chk("unmapped_err", 1, e);
        apb(1, 12'h000, 8'h01);
        apb(0, 12'h000, 8'h00);
        chk("flag_ro", 32'h00000000, r);
    endtask
    task automatic t_timebase;
        apb(1, 12'h000, 8'h02);
        apb(0, 12'h000, 8'h00);
        wait_irq(t0);
        for (int c = 1; c < 4; c++) begin
            apb(1, 12'h000, {4'h0, c[1:0], 2'b10});
            apb(0, 12'h000, 8'h00);
            chk("flag_set", 1, r[0]);
            wait_irq(t1);
            chk("old_len", len[c-1], t1 - t0);
            apb(0, 12'h000, 8'h00);
            wait_irq(t0);
            chk("new_len", len[c], t0 - t1);
        end
    endtask
    task automatic t_mask;
        apb(1, 12'h000, 8'h00);
        apb(0, 12'h000, 8'h00);
        repeat (250) @(posedge pclk);
        chk("irq_disabled", 0, tb_irq);
        cpu_irq_masked <= 1;
        apb(1, 12'h000, 8'h02);
        repeat (5) @(posedge pclk);
        chk("irq_masked", 0, tb_irq);
        cpu_irq_masked <= 0;
        repeat (3) @(posedge pclk);
        chk("irq_unmasked", 1, tb_irq);
    endtask
    task automatic t_slow;
        for (int c = 0; c < 5; c++) begin
            apb(1, 12'h000, (c < 4) ? {1'b0, c[1:0], 1'b1, 4'h0} : 8'h00);
            repeat (20) @(posedge pclk);
            n = 0;
            m = 0;
            repeat (64) begin
                @(posedge pclk);
                n += (cpu_clk_en === 1'b1);
                m += (periph_clk_en === 1'b1);
            end
            chk("cpu_ticks", (c < 4) ? 64 >> (c + 1) : 64, n);
            chk("periph_ticks", (c < 4) ? 64 >> (c + 1) : 64, m);
        end
    endtask
    task automatic t_modes;
        apb(1, 12'h000, 8'h92);
        apb(0, 12'h000, 8'h00);
        wait_instr <= 1;
        @(posedge pclk);
        wait_instr <= 0;
        repeat (3) @(posedge pclk);
        chk("wait_stop", 1, cpu_stopped);
        chk("wait_out", 1, clock_output_pin_oe);
        m = 0;
        repeat (8) begin
            @(posedge pclk);
            m += (periph_clk_en === 1'b1);
        end
        chk("slow_wait", 4, m);
        wait_run("wait_wake");
        halt_instr <= 1;
        @(posedge pclk);
        halt_instr <= 0;
        repeat (3) @(posedge pclk);
        chk("ahalt_osc", 1, osc_running);
        chk("ahalt_out", 0, clock_output_pin_oe);
        apb(1, 12'h000, 8'h00);
        wait_run("ahalt_wake");
        apb(0, 12'h000, 8'h00);
        chk("ahalt_frozen", 7'h49, r[7:1]);
        apb(1, 12'h000, 8'h00);
        halt_instr <= 1;
        @(posedge pclk);
        halt_instr <= 0;
        repeat (50) @(posedge pclk);
        chk("halt_osc", 0, osc_running);
        ext_wake <= 1;
        @(posedge pclk);
        ext_wake <= 0;
        repeat (3) @(posedge pclk);
        chk("halt_exit", 0, cpu_stopped);
    endtask
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard: the whole sequence needs about 1300 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, cpu_irq_masked, halt_instr, wait_instr, ext_wake} = 8'h00;
        {paddr, pwdata, pstrb} = {12'h000, 32'h00000000, 4'hF};
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset;
        t_timebase;
        t_mask;
        t_slow;
        t_modes;
        end_sim;
    end
endmodule
